// ### rtl/mode_cfg_defines.svh
// Constants for the mode register configuration link
`ifndef MODE_CFG_DEFINES_SVH
`define MODE_CFG_DEFINES_SVH
`define MR_WIDTH        22
`define MR_SEL_HI       20
`define MR_SEL_LO       18
`define MR_SEL_ZERO     3'h0
`define MR_SEL_ONE      3'h1
`define MR_SEL_BAD      3'h7
`define MR0_TEST_BIT    7
`define MR0_DLL_RST_BIT 8
`define MR0_CL_HI       6
`define MR0_CL_LO       2
`define MR0_WR_HI       11
`define MR0_WR_LO       9
`define MR1_QOFF_BIT    12
`define MR1_TERM_STROBE_PINS_BIT    11
`define MR1_RTT_HI      10
`define MR1_RTT_LO      8
`define MR1_WLEV_BIT    7
`define MR1_AL_HI       4
`define MR1_AL_LO       3
`define MR1_ODI_HI      2
`define MR1_ODI_LO      1
`define MR1_DLL_BIT     0
`define MR1_RESET       22'h000001
`define MR0_RESET       22'h000000
`define CL_BASE         6'h09
`define LOCK_TIME_NS    15360
`define SYS_CLK_MHZ     50
`define LOCK_CYCLES     ((`LOCK_TIME_NS * `SYS_CLK_MHZ) / 1000)
`define LINK_DIV        4
`endif

// ### rtl/mode_cfg_pkg.sv
// Types shared by both ends of the mode register link
package mode_cfg_pkg;
    typedef logic [21:0] mr_word_t;
    typedef enum logic [1:0] {
        AL_ZERO,
        AL_CL_M1,
        AL_CL_M2,
        AL_RSVD
    } added_delay_e;
    typedef struct packed {
        logic       out_off;
        logic       term_strobe_pins;
        logic [2:0] nominal_termination;
        logic       write_level;
        logic [2:0] rx_equalizer;
        logic [1:0] added_delay;
        logic [1:0] drive_impedance;
        logic       dll_enable;
    } mode_one_s;
endpackage

// ### rtl/mode_link_if.sv
// Command/address link between controller and memory device
`timescale 1ns/1ps
interface mode_link_if;
    logic        ck;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [17:0] addr;
    logic        odt;
    modport dev  (input ck, cke, cs_n, ras_n, cas_n, we_n, bg, ba, addr, odt);
    modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, bg, ba, addr,
                  odt);
endinterface

// ### rtl/mode_cfg_device.sv
// Memory device end: mode register decode and loop state
`timescale 1ns/1ps
`include "mode_cfg_defines.svh"
module mode_cfg_device
    import mode_cfg_pkg::*;
#(
    parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_clk_en,
    // Link
    mode_link_if.dev        link,
    // Device state
    input  wire logic       i_self_refresh,
    input  wire logic       i_write_term_en,
    input  wire logic       i_wr_crc_fail,
    input  wire logic       i_dm_crc_en,
    output logic            o_out_off,
    output logic            o_term_strobe_pins,
    output logic [2:0]      o_nominal_termination,
    output logic [2:0]      o_term_applied,
    output logic            o_write_level,
    output logic [2:0]      o_rx_equalizer,
    output logic [1:0]      o_drive_impedance,
    output logic [5:0]      o_total_read_delay,
    output logic [4:0]      o_column_access_delay,
    output logic [2:0]      o_write_recovery,
    output logic            o_test_mode,
    output logic            o_dll_on,
    output logic            o_dll_locked,
    output logic            o_dll_reset_pulse,
    output logic            o_write_ok,
    output logic            o_write_discard
);
    // Two-stage sync of every link pin
    logic [28:0] sync1;
    logic [28:0] sync2;
    logic        ck_prev;
    mr_word_t    mode_reg_zero;
    mr_word_t    mode_reg_one;
    logic        dll_rst_req;
    logic [31:0] lock_cnt;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (i_clk_en) begin
            sync1 <= {link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n,
                      link.we_n, link.bg, link.ba, link.addr, link.odt};
            sync2 <= sync1;
        end
    end

    // Synced layout: ck 28, cke 27, strobes 26:23, bg 22:21, ba 20:19,
    // addr 18:1, odt 0
    logic        s_ck;
    logic        s_cke;
    logic        s_cmd_low;
    logic        s_odt;
    assign s_ck      = sync2[28];
    assign s_cke     = sync2[27];
    assign s_cmd_low = ~|sync2[26:23];
    assign s_odt     = sync2[0];

    // Address word: bg 21:20, ba 19:18, a17, a13..a0
    function automatic mr_word_t pack_word(input logic [1:0] bg,
                                           input logic [1:0] ba,
                                           input logic [17:0] a);
        pack_word = {bg, ba, a[17], 3'h0, a[13:0]};
    endfunction

    mr_word_t cmd_word;
    logic     ck_rise;
    logic     mrs_take;
    assign cmd_word = pack_word(sync2[22:21], sync2[20:19], sync2[18:1]);
    assign ck_rise  = s_ck & ~ck_prev;
    assign mrs_take = ck_rise & s_cke & s_cmd_low;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ck_prev <= 1'b0;
        end else if (i_clk_en) begin
            ck_prev <= s_ck;
        end
    end

    logic [2:0] sel;
    assign sel = cmd_word[`MR_SEL_HI:`MR_SEL_LO];

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_reg_one  <= `MR1_RESET;
            mode_reg_zero <= `MR0_RESET;
        end else if (i_clk_en && mrs_take) begin
            if (sel == `MR_SEL_ONE) begin
                mode_reg_one <= cmd_word;
            end else if (sel == `MR_SEL_ZERO) begin
                mode_reg_zero <= cmd_word;
                mode_reg_zero[`MR0_DLL_RST_BIT] <= 1'b0;
            end
        end
    end

    // Loop reset pulse and lock counter
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dll_rst_req <= 1'b0;
        end else if (i_clk_en) begin
            dll_rst_req <= mrs_take && sel == `MR_SEL_ZERO &&
                           cmd_word[`MR0_DLL_RST_BIT];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lock_cnt <= '0;
        end else if (i_clk_en) begin
            if (dll_rst_req || !o_dll_on) begin
                lock_cnt <= '0;
            end else if (lock_cnt < LOCK_CYCLES && ck_rise && s_cke) begin
                lock_cnt <= lock_cnt + 32'h1;
            end
        end
    end

    mode_one_s f;
    assign f = '{out_off:             mode_reg_one[`MR1_QOFF_BIT],
                 term_strobe_pins:    mode_reg_one[`MR1_TERM_STROBE_PINS_BIT],
                 nominal_termination: mode_reg_one[`MR1_RTT_HI:`MR1_RTT_LO],
                 write_level:         mode_reg_one[`MR1_WLEV_BIT],
                 rx_equalizer:        {mode_reg_one[13], mode_reg_one[6:5]},
                 added_delay:         mode_reg_one[`MR1_AL_HI:`MR1_AL_LO],
                 drive_impedance:     mode_reg_one[`MR1_ODI_HI:`MR1_ODI_LO],
                 dll_enable:          mode_reg_one[`MR1_DLL_BIT]};

    logic [4:0] cl;
    logic [4:0] al;
    assign cl = 5'(`CL_BASE) + 5'(mode_reg_zero[`MR0_CL_HI:`MR0_CL_LO]);
    always_comb begin
        case (added_delay_e'(f.added_delay))
            AL_CL_M1: al = cl - 5'h01;
            AL_CL_M2: al = cl - 5'h02;
            default:  al = 5'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_out_off             <= 1'b0;
            o_term_strobe_pins    <= 1'b0;
            o_nominal_termination <= 3'h0;
            o_term_applied        <= 3'h0;
            o_write_level         <= 1'b0;
            o_rx_equalizer        <= 3'h0;
            o_drive_impedance     <= 2'h0;
            o_total_read_delay    <= 6'h00;
            o_column_access_delay <= 5'h00;
            o_write_recovery      <= 3'h0;
            o_test_mode           <= 1'b0;
            o_dll_on              <= 1'b0;
            o_dll_locked          <= 1'b0;
            o_dll_reset_pulse     <= 1'b0;
            o_write_ok            <= 1'b0;
            o_write_discard       <= 1'b0;
        end else if (i_clk_en) begin
            o_out_off             <= f.out_off;
            o_term_strobe_pins    <= f.term_strobe_pins;
            o_nominal_termination <= f.nominal_termination;
            o_term_applied        <= (f.out_off || !o_dll_on || !s_odt) ?
                                     3'h0 : f.nominal_termination;
            o_write_level         <= f.write_level;
            o_rx_equalizer        <= f.rx_equalizer;
            o_drive_impedance     <= f.drive_impedance;
            o_column_access_delay <= cl;
            o_total_read_delay    <= 6'(al) + 6'(cl);
            o_write_recovery      <= mode_reg_zero[`MR0_WR_HI:`MR0_WR_LO];
            o_test_mode           <= mode_reg_zero[`MR0_TEST_BIT];
            o_dll_on              <= f.dll_enable && !i_self_refresh;
            o_dll_locked          <= o_dll_on && !dll_rst_req &&
                                     lock_cnt >= LOCK_CYCLES;
            o_dll_reset_pulse     <= dll_rst_req;
            o_write_ok            <= !(i_dm_crc_en && i_wr_crc_fail) &&
                                     (!i_write_term_en || o_dll_on);
            o_write_discard       <= i_dm_crc_en && i_wr_crc_fail;
        end
    end
endmodule // mode_cfg_device

// ### rtl/mode_cfg_ctrl.sv
// Controller end: issues mode register set commands
`timescale 1ns/1ps
`include "mode_cfg_defines.svh"
module mode_cfg_ctrl
    import mode_cfg_pkg::*;
#(
    parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_clk_en,
    // User request
    input  wire logic        i_req,
    input  wire logic [2:0]  i_sel,
    input  wire mr_word_t    i_data,
    input  wire logic        i_odt,
    output logic             o_busy,
    // Link
    mode_link_if.ctrl        link
);
    typedef enum logic [1:0] {IDLE, SETUP, HOLD, LOCKW} st_e;
    st_e         st;
    logic [2:0]  div;
    logic        ck_q;
    logic        dll_off;
    mr_word_t    word;
    logic [31:0] wait_cnt;
    logic        tick;
    assign tick = (div == 3'(`LINK_DIV - 1)) & ck_q;

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div  <= 3'h0;
            ck_q <= 1'b0;
        end else if (i_clk_en) begin
            if (div == 3'(`LINK_DIV - 1)) begin
                div  <= 3'h0;
                ck_q <= ~ck_q;
            end else begin
                div <= div + 3'h1;
            end
        end
    end

    function automatic mr_word_t clean(input logic [2:0] s,
                                       input mr_word_t d);
        clean = d;
        clean[21] = 1'b0;
        clean[17] = 1'b0;
        clean[13] = (s == `MR_SEL_ONE) ? d[13] : 1'b0;
        clean[`MR_SEL_HI:`MR_SEL_LO] = s;
        if (s == `MR_SEL_ZERO) begin
            clean[`MR0_TEST_BIT] = 1'b0;
        end
        if (s == `MR_SEL_ONE && !d[`MR1_DLL_BIT]) begin
            clean[`MR1_RTT_HI:`MR1_RTT_LO] = 3'h0;
        end
        if (s == `MR_SEL_ONE && d[`MR1_AL_HI:`MR1_AL_LO] == 2'h3) begin
            clean[`MR1_AL_HI:`MR1_AL_LO] = 2'h0;
        end
    endfunction

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st       <= IDLE;
            word     <= '0;
            wait_cnt <= '0;
            dll_off  <= 1'b0;
        end else if (i_clk_en) begin
            case (st)
                IDLE: if (i_req && i_sel != `MR_SEL_BAD) begin
                    word <= clean(i_sel, i_data);
                    st   <= SETUP;
                end
                SETUP: if (tick) st <= HOLD;
                HOLD: if (tick) begin
                    if (word[`MR_SEL_HI:`MR_SEL_LO] == `MR_SEL_ONE)
                        dll_off <= !word[`MR1_DLL_BIT];
                    wait_cnt <= '0;
                    st <= (word[`MR_SEL_HI:`MR_SEL_LO] == `MR_SEL_ZERO &&
                           word[`MR0_DLL_RST_BIT]) ? LOCKW : IDLE;
                end
                // Lock wait counted in link clock periods, one spare
                LOCKW: if (tick) begin
                    if (wait_cnt >= 32'(LOCK_CYCLES + 1)) begin
                        st <= IDLE;
                    end else begin
                        wait_cnt <= wait_cnt + 32'h1;
                    end
                end
                default: st <= IDLE;
            endcase
        end
    end

    logic drive;
    assign drive      = (st == HOLD);
    assign o_busy     = (st != IDLE);
    assign link.ck    = ck_q;
    assign link.cke   = 1'b1;
    assign link.cs_n  = ~drive;
    assign link.ras_n = ~drive;
    assign link.cas_n = ~drive;
    assign link.we_n  = ~drive;
    assign link.bg    = word[21:20];
    assign link.ba    = word[19:18];
    assign link.addr  = {word[17], 3'h0, word[13:0]};
    assign link.odt   = i_odt & ~dll_off;
endmodule // mode_cfg_ctrl

// ### tb/mode_cfg_assertions.sv
// Wire-level checks on the mode register set link
`timescale 1ns/1ps
module mode_cfg_assertions (
    // Clock and reset
    input wire logic        i_sys_clk,
    input wire logic        i_resetn,
    // Link
    input wire logic        ck,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [1:0]  bg,
    input wire logic [1:0]  ba,
    input wire logic [17:0] addr
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    logic cmd;
    assign cmd = !cs_n && !ras_n && !cas_n && !we_n;

    sequence s_cmd_start;
        $fell(ras_n);
    endsequence
    sequence s_cmd_held;
        (!ras_n && !cs_n && $stable(addr) && $stable(ba))[*3];
    endsequence

    a_strobes_together: assert property (!cs_n && !ras_n |-> !cas_n && !we_n)
        else $error("strobes not low together");
    a_sel_never_seven: assert property (cmd |-> {bg[0], ba} != 3'h7)
        else $error("select code seven issued");
    a_reserved_bits_zero: assert property (cmd |-> !bg[1] && !addr[17] &&
        ({bg[0], ba} == 3'h1 || !addr[13]))
        else $error("reserved bit set in command");
    a_test_bit_low: assert property (cmd && {bg[0], ba} == 3'h0 |-> !addr[7])
        else $error("test bit set in register zero");
    a_added_not_rsvd: assert property (cmd && {bg[0], ba} == 3'h1 |-> addr[4:3] != 2'h3)
        else $error("reserved added delay code sent");
    a_cke_held_high: assert property (cke)
        else $error("clock enable low");
    a_cmd_held_stable: assert property (s_cmd_start |=> s_cmd_held)
        else $error("command not held");
    a_ck_rise_in_cmd: assert property (s_cmd_start |-> ##[0:10] ($rose(ck) && !ras_n))
        else $error("no link clock edge during command");
endmodule // mode_cfg_assertions

// ### tb/tb.sv
// Testbench joining controller and device over the link
`timescale 1ns/1ps
module tb;
    import mode_cfg_pkg::*;
    localparam int LK = 16;
    logic       i_sys_clk, i_resetn, i_req, i_odt, o_busy;
    logic [2:0] i_sel;
    mr_word_t   i_data;
    logic       i_self_refresh, i_write_term_en, i_wr_crc_fail, i_dm_crc_en;
    logic       o_out_off, o_term_strobe_pins, o_write_level, o_test_mode;
    logic       o_dll_on, o_dll_locked, o_dll_reset_pulse;
    logic       o_write_ok, o_write_discard;
    logic [2:0] o_nominal_termination, o_term_applied, o_rx_equalizer;
    logic [2:0] o_write_recovery;
    logic [1:0] o_drive_impedance;
    logic [5:0] o_total_read_delay;
    logic [4:0] o_column_access_delay;
    int         errors, num_checks, pulses, lw;

    mode_link_if mode_link_if_i ();
    mode_cfg_ctrl #(.LOCK_CYCLES(LK)) mode_cfg_ctrl_i (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
        .i_clk_en(1'b1), .i_req(i_req), .i_sel(i_sel), .i_data(i_data),
        .i_odt(i_odt), .o_busy(o_busy), .link(mode_link_if_i));
    mode_cfg_device #(.LOCK_CYCLES(LK)) mode_cfg_device_i (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_clk_en(1'b1),
        .link(mode_link_if_i), .i_self_refresh(i_self_refresh),
        .i_write_term_en(i_write_term_en), .i_wr_crc_fail(i_wr_crc_fail),
        .i_dm_crc_en(i_dm_crc_en), .o_out_off(o_out_off),
        .o_term_strobe_pins(o_term_strobe_pins),
        .o_nominal_termination(o_nominal_termination),
        .o_term_applied(o_term_applied), .o_write_level(o_write_level),
        .o_rx_equalizer(o_rx_equalizer), .o_drive_impedance(o_drive_impedance),
        .o_total_read_delay(o_total_read_delay),
        .o_column_access_delay(o_column_access_delay),
        .o_write_recovery(o_write_recovery), .o_test_mode(o_test_mode),
        .o_dll_on(o_dll_on), .o_dll_locked(o_dll_locked),
        .o_dll_reset_pulse(o_dll_reset_pulse), .o_write_ok(o_write_ok),
        .o_write_discard(o_write_discard));
    mode_cfg_assertions mode_cfg_assertions_i (.i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn), .ck(mode_link_if_i.ck), .cke(mode_link_if_i.cke),
        .cs_n(mode_link_if_i.cs_n), .ras_n(mode_link_if_i.ras_n),
        .cas_n(mode_link_if_i.cas_n), .we_n(mode_link_if_i.we_n),
        .bg(mode_link_if_i.bg), .ba(mode_link_if_i.ba),
        .addr(mode_link_if_i.addr));

    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    // Loop reset pulses and cycles spent unlocked since the last one
    always @(posedge i_sys_clk) begin
        if (o_dll_reset_pulse === 1'b1) begin
            pulses++;
            lw = 0;
        end else if (o_dll_locked !== 1'b1) begin
            lw++;
        end
    end

    task check(input logic [21:0] seen, input logic [21:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task settle(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    task wr(input logic [2:0] sel, input mr_word_t d);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        i_req  <= 1'b1;
        i_sel  <= sel;
        i_data <= d;
        @(posedge i_sys_clk);
        i_req <= 1'b0;
        settle(2);
        while (o_busy !== 1'b0 && n < 400) begin
            settle(1);
            n++;
        end
        check(22'(o_busy), 22'h0);
        settle(12);
    endtask

    task results;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge i_sys_clk);
        errors++;
        results();
    end

    initial begin
        mr_word_t d;
        int       ad;
        i_resetn = 1'b0; i_req = 1'b0; i_sel = 3'h0; i_data = 22'h0;
        i_odt = 1'b1; i_self_refresh = 1'b0; i_write_term_en = 1'b0;
        i_wr_crc_fail = 1'b0; i_dm_crc_en = 1'b0;
        errors = 0; num_checks = 0; pulses = 0; lw = 0;
        repeat (20) @(posedge i_sys_clk);
        i_resetn <= 1'b1;
        settle(4);
        check(22'(o_column_access_delay), 22'h9);
        check(22'(o_total_read_delay), 22'h9);
        check(22'(o_dll_on), 22'h1);
        for (int i = 0; i < 8; i++) begin
            d = 22'h000001;
            d[12] = i[0]; d[11] = i[1]; d[10:8] = i[2:0]; d[7] = i[2];
            d[6:5] = i[1:0]; d[4:3] = i[1:0]; d[2:1] = i[2:1];
            d[13] = i[2];
            ad = (i[1:0] == 2'h1) ? 8 : (i[1:0] == 2'h2) ? 7 : 0;
            wr(3'h1, d);
            check(22'(o_out_off), 22'(i[0]));
            check(22'(o_term_strobe_pins), 22'(i[1]));
            check(22'(o_nominal_termination), 22'(i[2:0]));
            check(22'(o_write_level), 22'(i[2]));
            check(22'(o_rx_equalizer), 22'(i[2:0]));
            check(22'(o_drive_impedance), 22'(i[2:1]));
            check(22'(o_total_read_delay), 22'(9 + ad));
            check(22'(o_term_applied), i[0] ? 22'h0 : 22'(i[2:0]));
        end
        i_odt <= 1'b0;
        settle(20);
        check(22'(o_term_applied), 22'h0);
        i_odt <= 1'b1;
        wr(3'h0, 22'h000a0c);
        check(22'(o_column_access_delay), 22'h0c);
        check(22'(o_total_read_delay), 22'h0c);
        check(22'(o_write_recovery), 22'h5);
        check(22'(o_test_mode), 22'h0);
        check(22'(o_nominal_termination), 22'h7);
        wr(3'h1, 22'h000711);
        check(22'(o_total_read_delay), 22'h16);
        wr(3'h2, 22'h000000);
        check(22'(o_nominal_termination), 22'h7);
        wr(3'h7, 22'h000000);
        check(22'(o_nominal_termination), 22'h7);
        wr(3'h1, 22'h000700);
        check(22'(o_dll_on), 22'h0);
        check(22'(o_term_applied), 22'h0);
        i_write_term_en <= 1'b1;
        settle(8);
        check(22'(o_write_ok), 22'h0);
        i_write_term_en <= 1'b0;
        settle(8);
        check(22'(o_write_ok), 22'h1);
        wr(3'h1, 22'h000701);
        check(22'(o_dll_on), 22'h1);
        pulses = 0;
        wr(3'h0, 22'h000b0c);
        settle(3 * LK);
        check(22'(pulses), 22'h1);
        check(22'(o_dll_locked), 22'h1);
        check(22'(lw >= LK - 1), 22'h1);
        check(22'(o_column_access_delay), 22'h0c);
        i_self_refresh <= 1'b1;
        settle(8);
        check(22'(o_dll_on), 22'h0);
        i_self_refresh <= 1'b0;
        settle(8);
        check(22'(o_dll_on), 22'h1);
        i_dm_crc_en <= 1'b1;
        i_wr_crc_fail <= 1'b1;
        settle(6);
        check(22'(o_write_discard), 22'h1);
        i_dm_crc_en <= 1'b0;
        settle(6);
        check(22'(o_write_discard), 22'h0);
        results();
    end
endmodule // tb
